// ===== hdl/exec_pkg.sv
// Notes on behaviour
// RL1 - OR immediate: OR constant, Z N V, 1 cycle
// RL2 - Clear bits: AND inverted constant, 1 cycle
// RL3 - Test register: AND self, flags only; the code also writes the unchanged value back
// RL4 - Indirect jump: PC from pointer, 2 cycles
// RL5 - Indirect call: PC from pointer, 3 cycles
// RL6 - Compare skip equal: skip next when equal
// RL7 - Compare immediate: subtract, flags Z N V C H
// RL8 - Register bit skip on clear or set
// RL9 - I/O bit skip on clear or set
// RL10 - Flag branch: PC plus offset plus one
// RL11 - Named branches test carry, zero, negative
// RL12 - Skip advances two or three words
// RL13 - Offset signed, relative to next word
package exec_pkg;

  // ----------------------------------------
  // Operation codes presented by the decoder
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_OR_IMMEDIATE = 4'h1,
    OP_CLEAR_BITS = 4'h2,
    OP_TEST_REGISTER = 4'h3,
    OP_INDIRECT_JUMP = 4'h4,
    OP_INDIRECT_CALL = 4'h5,
    OP_COMPARE_SKIP_EQUAL = 4'h6,
    OP_COMPARE_IMMEDIATE = 4'h7,
    OP_SKIP_REG_BIT = 4'h8,
    OP_SKIP_IO_BIT = 4'h9,
    OP_BRANCH_FLAG = 4'ha
  } op_t;

  // ----------------------------------------
  // Status register bit positions
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // ----------------------------------------
  // Cycle counts and reset values
  // ----------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ----------------------------------------
  // Execution states, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;

endpackage

// ===== hdl/logic_compare_branch_exec.sv
// ----------------------------------------
// Execution of logic, compare, skip and branch operations
// ----------------------------------------
module logic_compare_branch_exec (
  // Clocking
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Instruction issue
  input wire logic issue,
  input wire exec_pkg::op_t op,
  input wire logic [7:0] reg_a,
  input wire logic [7:0] reg_b,
  input wire logic [7:0] imm_k,
  input wire logic [2:0] bit_sel,
  input wire logic bit_want,
  input wire logic [7:0] io_value,
  input wire logic [15:0] indirect_pointer,
  input wire logic [6:0] branch_offset,
  input wire logic next_is_two_word,
  // Status register in
  input wire logic [7:0] status_register,
  // Results
  output logic busy_q,
  output logic done_q,
  output logic [15:0] pc_q,
  output logic wr_en_q,
  output logic [7:0] wr_data_q,
  output logic flags_wr_q,
  output logic [7:0] flags_q,
  output logic push_q
);

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  // Idle or busy, one-hot
  exec_pkg::state_t state_q;
  // Next sequencer state
  exec_pkg::state_t state_d;
  // Cycles still owed by the current operation
  logic [1:0] cnt_q;
  // Next cycle count
  logic [1:0] cnt_d;
  // Next program counter
  logic [15:0] pc_d;
  // Next busy level
  logic busy_d;
  // Next completion pulse
  logic done_d;
  // Next register write strobe
  logic wr_en_d;
  // Next status load strobe
  logic flags_wr_d;
  // Next return-address push request
  logic push_d;
  // Next status byte
  logic [7:0] flags_d;

  // ----------------------------------------
  // Write-back bookkeeping
  // ----------------------------------------
  // A logic or compare result lands one cycle after issue
  logic pend_logic_q;
  // Next pending flag
  logic pend_logic_d;
  // Pending operation is a compare, so no register write
  logic cmp_q;
  // Next compare marker
  logic cmp_d;
  // Pending operation writes its destination register
  logic wb_q;
  // Next write-back marker
  logic wb_d;

  // ----------------------------------------
  // Logic unit connections
  // ----------------------------------------
  // Registered result byte of the unit
  logic [7:0] lu_result;
  // Registered flag bits of the unit
  logic [5:0] lu_flag;
  // Unit captures its operands this cycle
  logic lu_load;
  // Operation is handled by the logic unit
  logic is_logic_op;

  // Sign-extended word offset
  function automatic logic [15:0] sext(input logic [6:0] k);
    sext = {{9{k[6]}}, k};
  endfunction

  // Skip distance from word length of the following instruction
  function automatic logic [15:0] skip_step(input logic two_word);
    skip_step = two_word ? 16'h0003 : 16'h0002; // RL12
  endfunction

  assign is_logic_op = (op == exec_pkg::OP_OR_IMMEDIATE) ||
                       (op == exec_pkg::OP_CLEAR_BITS) ||
                       (op == exec_pkg::OP_TEST_REGISTER) ||
                       (op == exec_pkg::OP_COMPARE_IMMEDIATE);
  assign lu_load = issue && !busy_q && is_logic_op;

  // Byte logic and compare unit
  logic_unit u_logic (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(lu_load),
    .op(op),
    .operand_a(reg_a),
    .operand_k((op == exec_pkg::OP_TEST_REGISTER) ? reg_a : imm_k),
    .result_q(lu_result),
    .flag_q(lu_flag)
  );

  // ----------------------------------------
  // Program flow
  // ----------------------------------------
  // Next-state logic: PC flow and cycle counting
  // Every operation moves the PC in its first cycle, so a fetch unit
  // can start on the new address while the extra cycles are spent.
  // Skips and taken branches only differ in how many cycles they hold
  // the core; the counter makes the timing independent of the target.
  // A request that arrives while busy is not taken; the issuer must
  // keep it raised until busy falls, there is no queue behind it.
  // Named branches reach this block already mapped to a flag index and
  // a wanted level, which keeps the decoder table out of this logic.
  // Limitation: the call only raises a push request; storing the
  // return address is left to the stack logic outside this block.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    busy_d = busy_q;
    done_d = 1'b0;
    push_d = 1'b0;
    pend_logic_d = 1'b0;
    unique case (state_q)
      exec_pkg::ST_IDLE: begin
        if (issue) begin
          // Default: fall through to next word, one cycle
          pc_d = pc_q + 16'h0001;
          cnt_d = exec_pkg::CYC_ONE;
          unique case (op)
            exec_pkg::OP_OR_IMMEDIATE,
            exec_pkg::OP_CLEAR_BITS,
            exec_pkg::OP_TEST_REGISTER,
            exec_pkg::OP_COMPARE_IMMEDIATE: begin
              pend_logic_d = 1'b1; // RL1 RL2 RL3 RL7
            end
            exec_pkg::OP_INDIRECT_JUMP: begin
              pc_d = indirect_pointer; // RL4
              cnt_d = exec_pkg::CYC_TWO;
            end
            exec_pkg::OP_INDIRECT_CALL: begin
              // Return address push is left to the stack logic
              pc_d = indirect_pointer; // RL5
              cnt_d = exec_pkg::CYC_THREE;
              push_d = 1'b1;
            end
            exec_pkg::OP_COMPARE_SKIP_EQUAL: begin
              if (reg_a == reg_b) begin
                pc_d = pc_q + skip_step(next_is_two_word); // RL6
                cnt_d = next_is_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO; // RL12
              end
            end
            exec_pkg::OP_SKIP_REG_BIT: begin
              if (reg_a[bit_sel] == bit_want) begin
                pc_d = pc_q + skip_step(next_is_two_word); // RL8
                cnt_d = next_is_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO; // RL12
              end
            end
            exec_pkg::OP_SKIP_IO_BIT: begin
              if (io_value[bit_sel] == bit_want) begin
                pc_d = pc_q + skip_step(next_is_two_word); // RL9
                cnt_d = next_is_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO; // RL12
              end
            end
            exec_pkg::OP_BRANCH_FLAG: begin
              // Named branches map to a flag index and polarity
              if (status_register[bit_sel] == bit_want) begin
                pc_d = pc_q + sext(branch_offset) + 16'h0001; // RL10 RL11 RL13
                cnt_d = exec_pkg::CYC_TWO;
              end
            end
            default: begin
              pc_d = pc_q + 16'h0001;
            end
          endcase
          if (cnt_d == exec_pkg::CYC_ONE) begin
            done_d = 1'b1;
          end else begin
            state_d = exec_pkg::ST_BUSY;
            busy_d = 1'b1;
            cnt_d = cnt_d - 2'h1;
          end
        end
      end
      exec_pkg::ST_BUSY: begin
        // Hold until the counted cycles are spent
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == exec_pkg::CYC_ONE) begin
          state_d = exec_pkg::ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = exec_pkg::ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Result write-back
  // ----------------------------------------
  // Write-back of the logic unit result, one cycle after issue
  // Flags not owned by the operation come from the live status byte,
  // so a carry set by earlier arithmetic survives a logic operation.
  // The compare loads flags but never raises the register write.
  // Trade-off: the test operation writes its unchanged value back,
  // which costs nothing and saves a separate decode of that case.
  always_comb begin
    wr_en_d = 1'b0;
    flags_wr_d = 1'b0;
    flags_d = flags_q;
    if (pend_logic_q) begin
      flags_wr_d = 1'b1;
      flags_d = status_register;
      flags_d[exec_pkg::FLAG_Z] = lu_flag[exec_pkg::FLAG_Z];
      flags_d[exec_pkg::FLAG_N] = lu_flag[exec_pkg::FLAG_N];
      flags_d[exec_pkg::FLAG_V] = lu_flag[exec_pkg::FLAG_V];
      flags_d[exec_pkg::FLAG_S] = lu_flag[exec_pkg::FLAG_S];
      if (cmp_q) begin
        flags_d[exec_pkg::FLAG_C] = lu_flag[exec_pkg::FLAG_C]; // RL7
        flags_d[exec_pkg::FLAG_H] = lu_flag[exec_pkg::FLAG_H]; // RL7
      end else begin
        wr_en_d = wb_q; // RL1 RL2 RL3
      end
    end
  end

  // Compare discards result; test keeps value so write-back is harmless
  assign cmp_d = lu_load && (op == exec_pkg::OP_COMPARE_IMMEDIATE);
  assign wb_d = lu_load;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // State registers
  // Everything holds while the clock enable is low, so a stalled core
  // resumes the operation exactly where it stopped.
  // Reset drives constants only; the PC restarts at its reset address.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= exec_pkg::ST_IDLE;
      cnt_q <= 2'h0;
      pc_q <= exec_pkg::PC_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      push_q <= 1'b0;
      pend_logic_q <= 1'b0;
      cmp_q <= 1'b0;
      wb_q <= 1'b0;
      wr_en_q <= 1'b0;
      flags_wr_q <= 1'b0;
      flags_q <= exec_pkg::FLAGS_RESET;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      busy_q <= busy_d;
      done_q <= done_d;
      push_q <= push_d;
      pend_logic_q <= pend_logic_d;
      cmp_q <= cmp_d;
      wb_q <= wb_d;
      wr_en_q <= wr_en_d;
      flags_wr_q <= flags_wr_d;
      flags_q <= flags_d;
    end
  end

  // Result byte follows the unit's registered output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_data_q <= 8'h00;
    end else if (clk_en) begin
      wr_data_q <= lu_result;
    end
  end

endmodule

// ===== hdl/logic_unit.sv
// ----------------------------------------
// Byte logic and compare arithmetic
// ----------------------------------------
module logic_unit (
  // Clocking
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Operands
  input wire logic load,
  input wire exec_pkg::op_t op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_k,
  // Result, registered
  output logic [7:0] result_q,
  output logic [5:0] flag_q
);

  logic [7:0] result_d;
  logic [5:0] flag_d;
  logic [8:0] diff;

  // Result and flag computation for one operation
  always_comb begin
    result_d = result_q;
    flag_d = flag_q;
    diff = {1'b0, operand_a} - {1'b0, operand_k};
    if (load) begin
      unique case (op)
        exec_pkg::OP_OR_IMMEDIATE: result_d = operand_a | operand_k; // RL1
        exec_pkg::OP_CLEAR_BITS: result_d = operand_a & (exec_pkg::ALL_ONES - operand_k); // RL2
        exec_pkg::OP_TEST_REGISTER: result_d = operand_a & operand_a; // RL3
        exec_pkg::OP_COMPARE_IMMEDIATE: result_d = diff[7:0]; // RL7
        default: result_d = operand_a;
      endcase
      flag_d[exec_pkg::FLAG_Z] = (result_d == 8'h00);
      flag_d[exec_pkg::FLAG_N] = result_d[7];
      // Logic ops clear overflow; compare derives it from sign bits
      flag_d[exec_pkg::FLAG_V] = 1'b0;
      if (op == exec_pkg::OP_COMPARE_IMMEDIATE) begin
        flag_d[exec_pkg::FLAG_V] = (operand_a[7] & ~operand_k[7] & ~diff[7]) |
                                   (~operand_a[7] & operand_k[7] & diff[7]); // RL7
        flag_d[exec_pkg::FLAG_C] = diff[8]; // RL7
        flag_d[exec_pkg::FLAG_H] = ({1'b0, operand_a[3:0]} - {1'b0, operand_k[3:0]}) > 5'h0f; // RL7
      end
      flag_d[exec_pkg::FLAG_S] = flag_d[exec_pkg::FLAG_N] ^ flag_d[exec_pkg::FLAG_V];
    end
  end

  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= 8'h00;
      flag_q <= 6'h00;
    end else if (clk_en) begin
      result_q <= result_d;
      flag_q <= flag_d;
    end
  end

endmodule

// ===== verification/exec_monitor.sv
// -------------------------------
// Timing checks on the execute block
// -------------------------------
module exec_monitor (
  // Clocking
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Issue side
  input wire logic issue,
  input wire exec_pkg::op_t op,
  input wire logic [2:0] bit_sel,
  input wire logic bit_want,
  input wire logic [15:0] indirect_pointer,
  input wire logic [6:0] branch_offset,
  input wire logic [7:0] status_register,
  // Results
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic [15:0] pc_q,
  input wire logic wr_en_q,
  input wire logic flags_wr_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // An accepted request; busy blocks new ones
  wire take = issue && clk_en && !busy_q;
  // Branch match and widened offset
  wire hit = status_register[bit_sel] == bit_want;
  wire [15:0] sext = {{9{branch_offset[6]}}, branch_offset};
  a_or_one_cycle: assert property (take && op == exec_pkg::OP_OR_IMMEDIATE |=> done_q && !busy_q)
    else $error("or op not one cycle");
  a_clear_write: assert property (take && op == exec_pkg::OP_CLEAR_BITS |-> ##2 wr_en_q && flags_wr_q)
    else $error("clear bits did not write");
  a_test_write: assert property (take && op == exec_pkg::OP_TEST_REGISTER |=> ##1 flags_wr_q)
    else $error("test did not load flags");
  a_jump_two: assert property (take && op == exec_pkg::OP_INDIRECT_JUMP |=>
    busy_q && pc_q == $past(indirect_pointer) ##1 done_q && !busy_q)
    else $error("indirect jump timing");
  a_call_three: assert property (take && op == exec_pkg::OP_INDIRECT_CALL |=>
    pc_q == $past(indirect_pointer) ##0 busy_q [*2] ##1 done_q)
    else $error("indirect call timing");
  a_cmp_flags: assert property (take && op == exec_pkg::OP_COMPARE_IMMEDIATE |=>
    ##1 flags_wr_q && !wr_en_q)
    else $error("compare wrote register");
  a_skip_quiet: assert property (take && op inside {exec_pkg::OP_COMPARE_SKIP_EQUAL,
    exec_pkg::OP_SKIP_REG_BIT, exec_pkg::OP_SKIP_IO_BIT} |=> (!flags_wr_q && !wr_en_q) [*2])
    else $error("skip changed state");
  a_branch_pc: assert property (take && op == exec_pkg::OP_BRANCH_FLAG |=>
    pc_q == $past(pc_q) + 16'h0001 + ($past(hit) ? $past(sext) : 16'h0000))
    else $error("branch target wrong");
  a_branch_time: assert property (take && op == exec_pkg::OP_BRANCH_FLAG && !hit |=> done_q)
    else $error("untaken branch not one cycle");
endmodule

// ===== verification/io_port_model.sv
// -------------------------------
// I/O register seen by the bit skips
// -------------------------------
module io_port_model #(
  parameter logic [7:0] IO_INIT = 8'ha5
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic [7:0] io_value
);
  // Clears in reset so a stale value cannot fake a match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) io_value <= 8'h00;
    else io_value <= IO_INIT;
  end
endmodule

// ===== verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------
  // Stimulus and observed signals
  // -------------------------------
  logic clk = 0, reset_n = 0, clk_en = 1, issue = 0, w = 0, tw = 0;
  exec_pkg::op_t op = exec_pkg::OP_NONE;
  logic [7:0] a = 0, b = 0, k = 0, sr = 0, io_value, wr_data_q, flags_q;
  logic [2:0] s = 0;
  logic [6:0] f = 0;
  logic [15:0] ptr = 0, pc0, pc_q;
  logic busy_q, done_q, wr_en_q, flags_wr_q, push_q;
  logic [8:0] d;
  int mismatches = 0, tests_run = 0, n;
  always #2 clk = ~clk;
  io_port_model u_io (.clk, .reset_n, .io_value);
  logic_compare_branch_exec u_dut (.clk, .reset_n, .clk_en, .issue, .op, .reg_a(a), .reg_b(b),
    .imm_k(k), .bit_sel(s), .bit_want(w), .io_value, .indirect_pointer(ptr),
    .branch_offset(f), .next_is_two_word(tw), .status_register(sr), .busy_q, .done_q,
    .pc_q, .wr_en_q, .wr_data_q, .flags_wr_q, .flags_q, .push_q);
  // -------------------------------
  // Shared helpers
  // -------------------------------
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Issue one op; returns settled 1ns after the clock edge that takes it
  task go(input exec_pkg::op_t o, input logic [7:0] ra, rb, kk, rs, input logic [2:0] bs,
    input logic bw, input logic [6:0] bo, input logic t);
    @(posedge clk);
    op <= o; a <= ra; b <= rb; k <= kk; sr <= rs; s <= bs; w <= bw; f <= bo; tw <= t;
    ptr <= {ra, rb}; issue <= 1'b1;
    #1 pc0 = pc_q;
    @(posedge clk);
    issue <= 1'b0;
    #1;
  endtask
  // Bounded wait, so a stuck op cannot hang the run
  task wait_done(input int e);
    n = 1;
    while (done_q !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cycles", 16'(n), 16'(e));
  endtask
  // -------------------------------
  // Scenarios
  // -------------------------------
  task s_logic(input exec_pkg::op_t o, input logic [7:0] ra, kk, ex);
    // Carry, overflow and half set beforehand to see which survive
    go(o, ra, 0, kk, 8'h29, 0, 0, 0, 0);
    chk("pc", pc_q, pc0 + 16'h0001);
    wait_done(1);
    @(posedge clk);
    #1 chk("data", {8'h00, wr_data_q}, {8'h00, ex});
    chk("flags", {11'h000, flags_q[5], flags_q[3:0]}, {11'h001, 1'b0, ex[7], ex == 8'h00, 1'b1});
  endtask
  task s_cmp(input logic [7:0] ra, kk);
    d = {1'b0, ra} - {1'b0, kk};
    go(exec_pkg::OP_COMPARE_IMMEDIATE, ra, 0, kk, 8'h00, 0, 0, 0, 0);
    wait_done(1);
    @(posedge clk);
    #1 chk("cmp", {flags_q[5], flags_q[3:0]}, {ra[3:0] < kk[3:0],
      (ra[7] != kk[7]) && (d[7] != ra[7]), d[7], d[7:0] == 8'h00, d[8]});
  endtask
  task s_ind(input exec_pkg::op_t o, input logic [7:0] hi, lo, input int e);
    go(o, hi, lo, 0, 0, 0, 0, 0, 0);
    chk("target", pc_q, {hi, lo});
    wait_done(e);
  endtask
  task s_skip(input exec_pkg::op_t o, input logic [7:0] ra, rb, input logic [2:0] bs,
    input logic bw, t, sk);
    go(o, ra, rb, 0, 8'hff, bs, bw, 0, t);
    chk("skip pc", pc_q, pc0 + (sk ? 16'h0002 + 16'(t) : 16'h0001));
    wait_done(sk ? 2 + int'(t) : 1);
  endtask
  task s_branch();
    for (int i = 0; i < 12; i++) begin
      // Both offset extremes, flag bits 0 to 2 (C Z N), both wanted levels
      logic [7:0] rs;
      logic [6:0] bo;
      logic h;
      rs = (i >= 6) ? 8'hff : 8'h00;
      bo = i[0] ? 7'h40 : 7'h3f;
      h = rs[i % 3] == i[1];
      go(exec_pkg::OP_BRANCH_FLAG, 0, 0, 0, rs, 3'(i % 3), i[1], bo, 0);
      chk("br pc", pc_q, pc0 + 16'h0001 + (h ? {{9{bo[6]}}, bo} : 16'h0000));
      wait_done(h ? 2 : 1);
    end
  endtask
  // -------------------------------
  // Sequence and verdict
  // -------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    s_logic(exec_pkg::OP_OR_IMMEDIATE, 8'h0f, 8'hf0, 8'hff);
    s_logic(exec_pkg::OP_CLEAR_BITS, 8'hff, 8'hff, 8'h00);
    s_logic(exec_pkg::OP_CLEAR_BITS, 8'h7e, 8'h0f, 8'h70);
    s_logic(exec_pkg::OP_TEST_REGISTER, 8'h80, 8'h00, 8'h80);
    s_cmp(8'h10, 8'h01);
    s_cmp(8'h00, 8'h01);
    s_cmp(8'h80, 8'h01);
    s_ind(exec_pkg::OP_INDIRECT_JUMP, 8'h12, 8'h34, 2);
    s_ind(exec_pkg::OP_INDIRECT_CALL, 8'h04, 8'h56, 3);
    s_skip(exec_pkg::OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 0, 0, 0, 1);
    s_skip(exec_pkg::OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 0, 0, 1, 0);
    s_skip(exec_pkg::OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 0, 0, 1, 1);
    s_skip(exec_pkg::OP_SKIP_REG_BIT, 8'h10, 0, 3'h4, 1, 0, 1);
    s_skip(exec_pkg::OP_SKIP_REG_BIT, 8'h10, 0, 3'h4, 0, 1, 0);
    s_skip(exec_pkg::OP_SKIP_REG_BIT, 8'hef, 0, 3'h4, 0, 1, 1);
    s_skip(exec_pkg::OP_SKIP_IO_BIT, 0, 0, 3'h0, 1, 0, 1);
    s_skip(exec_pkg::OP_SKIP_IO_BIT, 0, 0, 3'h1, 1, 0, 0);
    s_skip(exec_pkg::OP_SKIP_IO_BIT, 0, 0, 3'h1, 0, 1, 1);
    s_branch();
    final_report();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule
bind logic_compare_branch_exec exec_monitor u_mon (.clk, .reset_n, .clk_en, .issue, .op,
  .bit_sel, .bit_want, .indirect_pointer, .branch_offset, .status_register, .busy_q,
  .done_q, .pc_q, .wr_en_q, .flags_wr_q);
